/* dv/far_node.sv */
// remote serial node driving the framer receive pins
`timescale 1ns/10ps
`default_nettype none
module far_node
    import framer_pkg::*;
#(
    parameter int HALF = 4
) (
    output var logic rxd,
    output var logic rxclk_in
);
    localparam int BIT_NS = 16 * HALF;
    initial begin
        rxd = LINE_IDLE;
        rxclk_in = 1'b0;
    end
    task automatic send_async(input logic [7:0] d, input int nbits,
                              input logic [1:0] par, input int halves,
                              input logic bad);
        logic p;
        int   i;
        p = (^(d & (8'hFF >> (8 - nbits)))) ^ (par == PAR_ODD) ^ bad;
        rxd = LINE_START;
        #(BIT_NS);
        for (i = 0; i < nbits; i++) begin
            rxd = d[i];
            #(BIT_NS);
        end
        if (par != PAR_NONE) begin
            rxd = p;
            #(BIT_NS);
        end
        rxd = LINE_IDLE;
        #(8 * HALF * halves);
    endtask
    task automatic send_sync(input logic [7:0] d);
        int i;
        for (i = 0; i < 8; i++) begin
            rxd = d[i];
            #20 rxclk_in = 1'b1;
            #40 rxclk_in = 1'b0;
            #20;
        end
        rxd = ~rxd;
    endtask
endmodule
`default_nettype wire

/* dv/framer_asserts.sv */
// concurrent checks on the serial framer ports
`timescale 1ns/10ps
`default_nettype none
module framer_asserts
    import framer_pkg::*;
(
    input wire logic                          clock,
    input wire logic                          reset,
    input wire logic                          sync_mode,
    input wire logic [framer_pkg::DIV_W-1:0]  half_bit_div,
    input wire logic                          tx_valid,
    input wire logic                          tx_ready,
    input wire logic [framer_pkg::CHAR_W-1:0] rx_data,
    input wire logic                          rx_parity_err,
    input wire logic                          rx_valid,
    input wire logic                          rx_ready,
    input wire logic                          rx_overrun,
    input wire logic                          rx_eot,
    input wire logic                          rx_locked,
    input wire logic                          txd,
    input wire logic                          txclk_out
);
    logic        prev_txd_r, prev_txd_nxt, armed_r, armed_nxt, txd_chg;
    logic [15:0] run_r, run_nxt;
    assign txd_chg = txd != prev_txd_r;
    // length of each txd level in cycles
    always_comb begin
        prev_txd_nxt = txd;
        armed_nxt    = armed_r | txd_chg;
        run_nxt      = txd_chg ? 16'h0001 : run_r + 16'h0001;
        if (reset) begin
            prev_txd_nxt = LINE_IDLE;
            armed_nxt    = 1'b0;
            run_nxt      = 16'h0001;
        end
    end
    always_ff @(posedge clock) begin
        prev_txd_r <= prev_txd_nxt;
        armed_r    <= armed_nxt;
        run_r      <= run_nxt;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    a_reset_idle: assert property (disable iff (1'b0)
        reset |=> txd && !txclk_out && !rx_valid && !rx_locked)
        else $error("line not idle after reset");
    a_start_bit: assert property (tx_valid && tx_ready && !sync_mode |=> !txd)
        else $error("no start bit after accept");
    a_ready_pulse: assert property (tx_valid && tx_ready |=> !tx_ready)
        else $error("second accept while busy");
    a_bit_timing: assert property (txd_chg && armed_r && !sync_mode |-> (run_r % half_bit_div) == 16'h0000)
        else $error("txd level not whole half bits");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_parity_err))
        else $error("held character changed");
    a_overrun_full: assert property (rx_overrun |-> rx_valid)
        else $error("overrun with empty buffer");
    a_eot_locked: assert property (rx_eot |-> $past(rx_locked))
        else $error("end pattern while hunting");
    a_eot_unlock: assert property (rx_eot |=> !rx_locked && !rx_eot)
        else $error("still locked after end pattern");
    a_txclk_async: assert property (!sync_mode |-> !txclk_out)
        else $error("bit clock in async mode");
    a_sync_edge: assert property (sync_mode && txd_chg |-> !txclk_out)
        else $error("txd moved with bit clock high");
    cover property (tx_valid && tx_ready);
    cover property (rx_overrun);
    cover property (rx_eot);
    cover property ($rose(rx_locked));
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the serial framer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import framer_pkg::*;
    localparam int H = 4;
    logic       clock, reset, sync_mode, tx_valid, tx_ready, rx_ready, ok;
    logic       rx_parity_err, rx_frame_err, rx_valid, rx_overrun, rx_eot;
    logic       rx_locked, txd, txclk_out, rxd, rxclk_in;
    logic [1:0] data_bits_sel, parity_sel, stop_sel;
    logic [7:0] sync_pattern, eot_pattern, tx_data, rx_data;
    logic [15:0] half_bit_div;
    int         mismatches, samples_checked, cycles, eot_seen, ovr_seen, c;
    logic [1:0] bsel [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
    logic [1:0] psel [4] = '{PAR_NONE, PAR_EVEN, PAR_ODD, 2'h3};
    logic [1:0] ssel [4] = '{STOP_1, 2'h2, STOP_15, STOP_1};
    logic [7:0] dat [4] = '{8'hA5, 8'h13, 8'h5C, 8'h2D};
    serial_framer u_dut (
        .clock(clock), .reset(reset), .sync_mode(sync_mode),
        .data_bits_sel(data_bits_sel), .parity_sel(parity_sel),
        .stop_sel(stop_sel), .half_bit_div(half_bit_div),
        .sync_pattern(sync_pattern), .eot_pattern(eot_pattern),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_parity_err(rx_parity_err),
        .rx_frame_err(rx_frame_err), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_overrun(rx_overrun), .rx_eot(rx_eot),
        .rx_locked(rx_locked), .txd(txd), .txclk_out(txclk_out),
        .rxd(rxd), .rxclk_in(rxclk_in)
    );
    far_node #(.HALF(H)) u_far (.rxd(rxd), .rxclk_in(rxclk_in));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    function automatic logic [7:0] mask_of(input int k);
        return 8'hFF >> (3 - bsel[k]);
    endfunction
    function automatic logic par_of(input logic [7:0] d, input int k);
        return (^(d & mask_of(k))) ^ (psel[k] == PAR_ODD);
    endfunction
    function automatic int halves_of(input int k);
        return (ssel[k] == STOP_1) ? 2 : (ssel[k] == STOP_15) ? 3 : 4;
    endfunction
    task automatic give_verdict;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (rx_eot === 1'b1) eot_seen++;
        if (rx_overrun === 1'b1) ovr_seen++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic reset_dut(input logic sm, input int k);
        reset = 1'b1;
        sync_mode = sm;
        data_bits_sel = bsel[k];
        parity_sel = psel[k];
        stop_sel = ssel[k];
        step(5);
        reset = 1'b0;
    endtask
    task automatic tx_put(input logic [7:0] d, input logic last);
        int k;
        k = 0;
        tx_data = d;
        tx_valid = 1'b1;
        #1;
        while (tx_ready !== 1'b1 && k < 400) begin
            step(1);
            k++;
        end
        step(1);
        if (last) tx_valid = 1'b0;
        check_bit(k < 400, 1'b1);
    endtask
    task automatic expect_frame(input logic [7:0] d, input int k);
        int i, w;
        w = 0;
        while (txd !== 1'b0 && w < 400) begin
            step(1);
            w++;
        end
        step(H);
        check_bit(txd, LINE_START);
        for (i = 0; i < int'(bsel[k]) + 5; i++) begin
            step(2 * H);
            check_bit(txd, d[i]);
        end
        if (psel[k] != PAR_NONE) begin
            step(2 * H);
            check_bit(txd, par_of(d, k));
        end
        step(H);
        check_bit(txd, LINE_IDLE);
        step(halves_of(k) * H - 1);
        check_bit(txd, LINE_IDLE);
    endtask
    task automatic pop(input logic [7:0] d, input logic perr);
        int k;
        k = 0;
        while (rx_valid !== 1'b1 && k < 400) begin
            step(1);
            k++;
        end
        check_byte(rx_data, d);
        check_bit(rx_parity_err, perr);
        check_bit(rx_frame_err, 1'b0);
        rx_ready = 1'b1;
        step(1);
        rx_ready = 1'b0;
        step(1);
    endtask
    task automatic watch(input logic [15:0] pat, output logic found);
        logic [15:0] win;
        logic        last;
        int          k;
        win = 16'h0000;
        last = 1'b0;
        found = 1'b0;
        for (k = 0; k < 800 && !found; k++) begin
            step(1);
            if (txclk_out === 1'b1 && last === 1'b0) win = {txd, win[15:1]};
            last = txclk_out;
            found = (win === pat);
        end
    endtask
    initial begin
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        half_bit_div = 16'h0004;
        sync_pattern = 8'h7E;
        eot_pattern = 8'h04;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        for (c = 0; c < 4; c++) begin
            reset_dut(1'b0, c);
            fork
                begin
                    tx_put(dat[c], 1'b0);
                    tx_put(~dat[c], 1'b1);
                end
                begin
                    expect_frame(dat[c], c);
                    expect_frame(~dat[c], c);
                end
            join
            u_far.send_async(dat[c], int'(bsel[c]) + 5, psel[c], halves_of(c), 1'b0);
            u_far.send_async(~dat[c], int'(bsel[c]) + 5, psel[c], halves_of(c), psel[c] != PAR_NONE);
            pop(dat[c] & mask_of(c), 1'b0);
            pop(~dat[c] & mask_of(c), psel[c] != PAR_NONE);
        end
        ovr_seen = 0;
        for (c = 0; c < 3; c++) u_far.send_async(dat[c], 6, 2'h3, 2, 1'b0);
        step(4);
        check_bit(ovr_seen == 1, 1'b1);
        pop(dat[0] & 8'h3F, 1'b0);
        pop(dat[1] & 8'h3F, 1'b0);
        check_bit(rx_valid, 1'b0);
        half_bit_div = 16'h0003;
        eot_pattern = 8'hE1;
        reset_dut(1'b1, 0);
        u_far.send_sync(8'h00);
        u_far.send_sync(8'h7E);
        step(6);
        check_bit(rx_locked, 1'b1);
        u_far.send_sync(8'h3C);
        u_far.send_sync(8'h7E);
        u_far.send_sync(8'hC3);
        pop(8'h3C, 1'b0);
        pop(8'hC3, 1'b0);
        eot_seen = 0;
        u_far.send_sync(8'hE1);
        step(6);
        check_bit(eot_seen == 1, 1'b1);
        check_bit(rx_locked, 1'b0);
        watch(16'h7E7E, ok);
        check_bit(ok, 1'b1);
        fork
            tx_put(8'h96, 1'b1);
            watch(16'h967E, ok);
        join
        check_bit(ok, 1'b1);
        give_verdict();
    end
endmodule
bind serial_framer framer_asserts u_chk (
    .clock(clock), .reset(reset), .sync_mode(sync_mode),
    .half_bit_div(half_bit_div), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_parity_err(rx_parity_err), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_overrun(rx_overrun), .rx_eot(rx_eot),
    .rx_locked(rx_locked), .txd(txd), .txclk_out(txclk_out)
);
`default_nettype wire

/* hw/serial_framer.sv */
// asynchronous and synchronous character framer
//
// Behaviour
// - async characters start with one start bit then 5 to 8 data bits.
// - async characters end with 1, 1.5 or 2 stop bit times.
// - with parity on, one parity bit sits after data, before stop bits.
// - parity is even, odd or none, set so the count of ones matches.
// - both ends use the same baud, parity, data and stop settings.
// - sync receive samples data on each rising edge of the remote clock.
// - in sync mode each direction is timed by its sender's clock, rates independent.
// - sync receive hunts the sync flag, then packs each 8 bits.
// - packing runs until the end-of-text pattern; further sync flags are dropped.
// - sync transmit sends sync characters when idle and before a block.
`timescale 1ns/10ps
`default_nettype none
module serial_framer
    import framer_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        reset,
    input  wire logic                        sync_mode,
    input  wire logic [1:0]                  data_bits_sel,
    input  wire logic [1:0]                  parity_sel,
    input  wire logic [1:0]                  stop_sel,
    input  wire logic [framer_pkg::DIV_W-1:0] half_bit_div,
    input  wire logic [framer_pkg::CHAR_W-1:0] sync_pattern,
    input  wire logic [framer_pkg::CHAR_W-1:0] eot_pattern,
    input  wire logic [framer_pkg::CHAR_W-1:0] tx_data,
    input  wire logic                        tx_valid,
    output logic                             tx_ready,
    output logic [framer_pkg::CHAR_W-1:0]    rx_data,
    output logic                             rx_parity_err,
    output logic                             rx_frame_err,
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    output logic                             rx_overrun,
    output logic                             rx_eot,
    output logic                             rx_locked,
    output logic                             txd,
    output logic                             txclk_out,
    input  wire logic                        rxd,
    input  wire logic                        rxclk_in
);
    import framer_pkg::*;

    localparam int ENT_W = CHAR_W + 2;

    function automatic logic [CHAR_W-1:0] data_mask(input logic [1:0] sel);
        data_mask = (sel == BITS_5) ? 8'h1F :
                    (sel == BITS_6) ? 8'h3F :
                    (sel == BITS_7) ? 8'h7F : 8'hFF;
    endfunction

    function automatic logic par_bit(input logic [CHAR_W-1:0] d,
                                     input logic [1:0] sel,
                                     input logic [1:0] mode);
        logic ones;
        ones = ^(d & data_mask(sel));
        par_bit = (mode == PAR_ODD) ? ~ones : ones;
    endfunction

    logic [3:0] nbits;
    logic [2:0] stop_halves;
    assign nbits = MIN_DATA_BITS + {2'h0, data_bits_sel};
    assign stop_halves = (stop_sel == STOP_1)  ? HALVES_STOP_1 :
                         (stop_sel == STOP_15) ? HALVES_STOP_15 :
                         HALVES_STOP_2;

    // input synchronisers
    logic [2:0] rxd_s_r;
    logic [2:0] rxclk_s_r;
    always_ff @(posedge clock) begin
        if (reset) begin
            rxd_s_r   <= {3{LINE_IDLE}};
            rxclk_s_r <= 3'h0;
        end else begin
            rxd_s_r   <= {rxd_s_r[1:0], rxd};
            rxclk_s_r <= {rxclk_s_r[1:0], rxclk_in};
        end
    end
    logic rxd_q;
    logic rxd_fall;
    logic rxclk_rise;
    assign rxd_q      = rxd_s_r[1];
    assign rxd_fall   = rxd_s_r[2] & ~rxd_s_r[1];
    assign rxclk_rise = ~rxclk_s_r[2] & rxclk_s_r[1];

    // transmitter
    tx_state_e         tx_state_r, tx_state_nxt;
    logic [DIV_W-1:0]  tx_div_r, tx_div_nxt;
    logic [2:0]        tx_half_r, tx_half_nxt;
    logic [3:0]        tx_left_r, tx_left_nxt;
    logic [CHAR_W-1:0] tx_shift_r, tx_shift_nxt;
    logic              tx_par_r, tx_par_nxt;
    logic              txd_r, txd_nxt;
    logic              txclk_r, txclk_nxt;
    logic              tx_block_r, tx_block_nxt;
    logic              tx_tick;
    logic              tx_bit_end;
    logic              take;

    assign tx_tick = (tx_div_r == '0);
    assign tx_ready = take & ~reset;

    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_div_nxt   = tx_tick ? half_bit_div - 1'b1 : tx_div_r - 1'b1;
        tx_half_nxt  = tx_half_r;
        tx_left_nxt  = tx_left_r;
        tx_shift_nxt = tx_shift_r;
        tx_par_nxt   = tx_par_r;
        txd_nxt      = txd_r;
        txclk_nxt    = txclk_r;
        tx_block_nxt = tx_block_r;
        take         = 1'b0;
        tx_bit_end   = 1'b0;
        if (tx_tick) begin
            tx_half_nxt = tx_half_r + 3'h1;
            if (tx_state_r == TX_STOP)
                tx_bit_end = (tx_half_r == stop_halves - 3'h1);
            else
                tx_bit_end = (tx_half_r == HALVES_PER_BIT - 3'h1);
            txclk_nxt = sync_mode & ~tx_bit_end & (tx_state_r == TX_DATA);
            if (tx_bit_end)
                tx_half_nxt = 3'h0;
        end
        case (tx_state_r)
            TX_IDLE: begin
                if (tx_tick) begin
                    tx_half_nxt = 3'h0;
                    if (sync_mode) begin
                        // sync when idle and ahead of block
                        take = tx_valid & tx_block_r;
                        tx_block_nxt = tx_valid;
                        tx_shift_nxt = take ? tx_data : sync_pattern;
                        tx_left_nxt  = CHAR_BITS;
                        txd_nxt      = tx_shift_nxt[0];
                        txclk_nxt    = 1'b0;
                        tx_state_nxt = TX_DATA;
                    end else if (tx_valid) begin
                        take = 1'b1;
                        tx_shift_nxt = tx_data;
                        tx_left_nxt  = nbits;
                        tx_par_nxt   = par_bit(tx_data, data_bits_sel,
                                               parity_sel);
                        txd_nxt      = LINE_START;
                        tx_state_nxt = TX_START;
                    end else begin
                        txd_nxt = LINE_IDLE;
                    end
                end
            end
            TX_START: begin
                if (tx_bit_end) begin
                    txd_nxt      = tx_shift_r[0];
                    tx_state_nxt = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_bit_end) begin
                    tx_shift_nxt = tx_shift_r >> 1;
                    tx_left_nxt  = tx_left_r - 4'h1;
                    txd_nxt      = tx_shift_nxt[0];
                    if (tx_left_r == 4'h1) begin
                        if (sync_mode) begin
                            tx_state_nxt = TX_IDLE;
                        end else if (parity_sel != PAR_NONE) begin
                            txd_nxt      = tx_par_r;
                            tx_state_nxt = TX_PAR;
                        end else begin
                            txd_nxt      = LINE_IDLE;
                            tx_state_nxt = TX_STOP;
                        end
                    end
                end
            end
            TX_PAR: begin
                if (tx_bit_end) begin
                    txd_nxt      = LINE_IDLE;
                    tx_state_nxt = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_bit_end)
                    tx_state_nxt = TX_IDLE;
            end
            default: tx_state_nxt = TX_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_state_r <= TX_IDLE;
            tx_div_r   <= '0;
            tx_half_r  <= 3'h0;
            tx_left_r  <= 4'h0;
            tx_shift_r <= '0;
            tx_par_r   <= 1'b0;
            txd_r      <= LINE_IDLE;
            txclk_r    <= 1'b0;
            tx_block_r <= 1'b0;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_div_r   <= tx_div_nxt;
            tx_half_r  <= tx_half_nxt;
            tx_left_r  <= tx_left_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_par_r   <= tx_par_nxt;
            txd_r      <= txd_nxt;
            txclk_r    <= txclk_nxt;
            tx_block_r <= tx_block_nxt;
        end
    end
    assign txd       = txd_r;
    assign txclk_out = txclk_r;

    // receiver, both modes
    rx_state_e         rx_state_r, rx_state_nxt;
    logic [DIV_W-1:0]  rx_div_r, rx_div_nxt;
    logic              rx_half_r, rx_half_nxt;
    logic [3:0]        rx_left_r, rx_left_nxt;
    logic [CHAR_W-1:0] rx_shift_r, rx_shift_nxt;
    logic              rx_perr_r, rx_perr_nxt;
    logic              locked_r, locked_nxt;
    logic              eot_r, eot_nxt;
    logic              push;
    logic [ENT_W-1:0]  push_ent;
    logic              rx_tick;
    logic              samp;
    logic [CHAR_W-1:0] win;

    assign rx_tick = (rx_div_r == '0);
    assign samp    = rx_tick & rx_half_r;
    assign win     = {rxd_q, rx_shift_r[CHAR_W-1:1]};

    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_div_nxt   = rx_tick ? half_bit_div - 1'b1 : rx_div_r - 1'b1;
        rx_half_nxt  = rx_tick ? ~rx_half_r : rx_half_r;
        rx_left_nxt  = rx_left_r;
        rx_shift_nxt = rx_shift_r;
        rx_perr_nxt  = rx_perr_r;
        locked_nxt   = locked_r;
        eot_nxt      = 1'b0;
        push         = 1'b0;
        push_ent     = {2'h0, rx_shift_r};
        if (sync_mode) begin
            rx_state_nxt = RX_IDLE;
            if (rxclk_rise) begin
                rx_shift_nxt = win;
                rx_left_nxt  = rx_left_r - 4'h1;
                if (!locked_r) begin
                    if (win == sync_pattern) begin
                        locked_nxt  = 1'b1;
                        rx_left_nxt = CHAR_BITS;
                    end
                end else if (rx_left_r == 4'h1) begin
                    rx_left_nxt = CHAR_BITS;
                    // stop on end of text, drop sync flag
                    if (win == eot_pattern) begin
                        locked_nxt = 1'b0;
                        eot_nxt    = 1'b1;
                    end else if (win != sync_pattern) begin
                        push     = 1'b1;
                        push_ent = {2'h0, win};
                    end
                end
            end
        end else begin
            locked_nxt = 1'b0;
            case (rx_state_r)
                RX_IDLE: begin
                    if (rxd_fall) begin
                        rx_div_nxt   = half_bit_div - 1'b1;
                        rx_half_nxt  = 1'b1;
                        rx_state_nxt = RX_START;
                    end
                end
                RX_START: begin
                    if (samp) begin
                        rx_left_nxt  = nbits;
                        rx_shift_nxt = '0;
                        rx_state_nxt = (rxd_q == LINE_START) ? RX_DATA
                                                             : RX_IDLE;
                    end
                end
                RX_DATA: begin
                    if (samp) begin
                        rx_shift_nxt = win;
                        rx_left_nxt  = rx_left_r - 4'h1;
                        if (rx_left_r == 4'h1) begin
                            rx_shift_nxt = win >> (CHAR_BITS - nbits);
                            rx_perr_nxt  = 1'b0;
                            rx_state_nxt = (parity_sel != PAR_NONE)
                                           ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (samp) begin
                        rx_perr_nxt = rxd_q != par_bit(rx_shift_r,
                                           data_bits_sel, parity_sel);
                        rx_state_nxt = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (samp) begin
                        push     = 1'b1;
                        push_ent = {rx_perr_r, rxd_q != LINE_IDLE,
                                    rx_shift_r};
                        rx_state_nxt = RX_IDLE;
                    end
                end
                default: rx_state_nxt = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rx_state_r <= RX_IDLE;
            rx_div_r   <= '0;
            rx_half_r  <= 1'b0;
            rx_left_r  <= 4'h0;
            rx_shift_r <= '0;
            rx_perr_r  <= 1'b0;
            locked_r   <= 1'b0;
            eot_r      <= 1'b0;
        end else begin
            rx_state_r <= rx_state_nxt;
            rx_div_r   <= rx_div_nxt;
            rx_half_r  <= rx_half_nxt;
            rx_left_r  <= rx_left_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_perr_r  <= rx_perr_nxt;
            locked_r   <= locked_nxt;
            eot_r      <= eot_nxt;
        end
    end
    assign rx_locked = locked_r;
    assign rx_eot    = eot_r;

    // two-entry receive buffer, head always in slot 0
    logic [ENT_W-1:0] ent0_r, ent0_nxt;
    logic [ENT_W-1:0] ent1_r, ent1_nxt;
    logic [1:0]       cnt_r, cnt_nxt;
    logic             ovr_r, ovr_nxt;
    logic             pop;

    assign pop = rx_ready & (cnt_r != 2'h0);

    always_comb begin
        ent0_nxt = ent0_r;
        ent1_nxt = ent1_r;
        cnt_nxt  = cnt_r;
        ovr_nxt  = push & ~pop & (cnt_r == 2'h2);
        if (pop) begin
            ent0_nxt = ent1_r;
            cnt_nxt  = cnt_r - 2'h1;
        end
        if (push && !(cnt_r == 2'h2 && !pop)) begin
            if (cnt_nxt == 2'h0)
                ent0_nxt = push_ent;
            else
                ent1_nxt = push_ent;
            cnt_nxt = cnt_nxt + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ent0_r <= '0;
            ent1_r <= '0;
            cnt_r  <= 2'h0;
            ovr_r  <= 1'b0;
        end else begin
            ent0_r <= ent0_nxt;
            ent1_r <= ent1_nxt;
            cnt_r  <= cnt_nxt;
            ovr_r  <= ovr_nxt;
        end
    end
    assign rx_valid      = (cnt_r != 2'h0);
    assign rx_data       = ent0_r[CHAR_W-1:0];
    assign rx_frame_err  = ent0_r[CHAR_W];
    assign rx_parity_err = ent0_r[CHAR_W+1];
    assign rx_overrun    = ovr_r;
endmodule
`default_nettype wire

/* inc/framer_pkg.sv */
// constants and types shared by the serial framer
package framer_pkg;
    localparam int unsigned CLK_HZ          = 125000000;
    localparam int unsigned DEFAULT_BAUD    = 9600;
    localparam int unsigned HALF_DIV_CALC   = CLK_HZ / (DEFAULT_BAUD * 2);
    localparam logic [15:0] DEFAULT_HALF_DIV = HALF_DIV_CALC[15:0];
    localparam int          DIV_W           = 16;
    localparam int          CHAR_W          = 8;
    localparam logic [3:0]  CHAR_BITS       = 4'h8;
    localparam logic [3:0]  MIN_DATA_BITS   = 4'h5;
    localparam logic [2:0]  HALVES_PER_BIT  = 3'h2;
    localparam logic [2:0]  HALVES_STOP_1   = 3'h2;
    localparam logic [2:0]  HALVES_STOP_15  = 3'h3;
    localparam logic [2:0]  HALVES_STOP_2   = 3'h4;
    localparam logic [1:0]  STOP_1          = 2'h0;
    localparam logic [1:0]  STOP_15         = 2'h1;
    localparam logic [1:0]  PAR_NONE        = 2'h0;
    localparam logic [1:0]  PAR_EVEN        = 2'h1;
    localparam logic [1:0]  PAR_ODD         = 2'h2;
    localparam logic [1:0]  BITS_5          = 2'h0;
    localparam logic [1:0]  BITS_6          = 2'h1;
    localparam logic [1:0]  BITS_7          = 2'h2;
    localparam logic        LINE_IDLE       = 1'h1;
    localparam logic        LINE_START      = 1'h0;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA  = 5'b00100,
        TX_PAR   = 5'b01000,
        TX_STOP  = 5'b10000
    } tx_state_e;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA  = 5'b00100,
        RX_PAR   = 5'b01000,
        RX_STOP  = 5'b10000
    } rx_state_e;
endpackage
